/* File: npe_consts.vh */
// Behaviour
// - Raw receiver packet id 29, 74 bytes
// - Seconds at byte 0, microseconds at 4
// - Raw lat/lon/height fp64 at 8/16/24, uncorrected
// - Raw NED velocity fp32 at 32/36/40
// - Raw position deviations fp32 at 44/48/52
// - Tilt, heading, deviations fp32 at 56-68
// - Receiver status u16 ends raw packet at 72
// - Status bit positions for fix and flags
// - Status bit 9 always zero
// - Bits 10-13 antenna disconnect and short flags
// - Bits 14/15 receiver failure flags
// - Satellites packet id 30, 13 bytes
// - Geodetic position packet id 32, 24 bytes
// - Earth-centred position packet id 33, 24 bytes
// - Grid position packet id 34, 26 bytes
// - NED velocity packet id 35, 12 bytes
// - Body velocity packet id 36, 12 bytes
// - Fused packets carry offset-corrected values
`ifndef NPE_CONSTS_VH
`define NPE_CONSTS_VH
`define NPE_OFF_CTRL        12'h000
`define NPE_OFF_STAT        12'h004
`define NPE_OFF_RXSTAT      12'h008
`define NPE_OFF_MEM         12'h100
`define NPE_OFF_MEM_END     12'h1FC
`define NPE_CTRL_ID_LSB     0
`define NPE_CTRL_START_BIT  8
`define NPE_STAT_BUSY_BIT   0
`define NPE_STAT_BADID_BIT  1
`define NPE_STAT_ID_LSB     8
`define NPE_STAT_CNT_LSB    16
`define NPE_ID_RAW          8'h1D
`define NPE_ID_SATS         8'h1E
`define NPE_ID_GEO          8'h20
`define NPE_ID_ECEF         8'h21
`define NPE_ID_GRID         8'h22
`define NPE_ID_NED          8'h23
`define NPE_ID_BODY         8'h24
`define NPE_LEN_RAW         7'h4A
`define NPE_LEN_SATS        7'h0D
`define NPE_LEN_GEO         7'h18
`define NPE_LEN_ECEF        7'h18
`define NPE_LEN_GRID        7'h1A
`define NPE_LEN_NED         7'h0C
`define NPE_LEN_BODY        7'h0C
`define NPE_BASE_RAW        6'h00
`define NPE_BASE_SATS       6'h14
`define NPE_BASE_GEO        6'h18
`define NPE_BASE_ECEF       6'h1E
`define NPE_BASE_GRID       6'h24
`define NPE_BASE_NED        6'h2B
`define NPE_BASE_BODY       6'h2E
`define NPE_RAW_STATUS_LO   7'h48
`define NPE_RAW_STATUS_HI   7'h49
`define NPE_RESP_OKAY       2'b00
`define NPE_RESP_SLVERR     2'b10
`endif

/* File: npe_id_decode.v */
`timescale 1ns/1ns
`include "npe_consts.vh"
module npe_id_decode (
    id,
    known,
    len,
    base
);
    input  wire [7:0] id;
    output reg        known;
    output reg  [6:0] len;
    output reg  [5:0] base;

    always @* begin
        known = 1'b1;
        len   = 7'h00;
        base  = 6'h00;
        case (id)
            `NPE_ID_RAW: begin
                len  = `NPE_LEN_RAW;
                base = `NPE_BASE_RAW;
            end
            `NPE_ID_SATS: begin
                len  = `NPE_LEN_SATS;
                base = `NPE_BASE_SATS;
            end
            `NPE_ID_GEO: begin
                len  = `NPE_LEN_GEO;
                base = `NPE_BASE_GEO;
            end
            `NPE_ID_ECEF: begin
                len  = `NPE_LEN_ECEF;
                base = `NPE_BASE_ECEF;
            end
            `NPE_ID_GRID: begin
                len  = `NPE_LEN_GRID;
                base = `NPE_BASE_GRID;
            end
            `NPE_ID_NED: begin
                len  = `NPE_LEN_NED;
                base = `NPE_BASE_NED;
            end
            `NPE_ID_BODY: begin
                len  = `NPE_LEN_BODY;
                base = `NPE_BASE_BODY;
            end
            default: begin
                known = 1'b0;
            end
        endcase
    end
endmodule // npe_id_decode

/* File: npe_encoder.v */
`timescale 1ns/1ns
`include "npe_consts.vh"
module npe_encoder #(
    parameter ADDR_W         = 12,
    parameter MEM_WORDS      = 64,
    parameter HAS_ANT_DETECT = 1,
    parameter HAS_SECONDARY  = 1
) (
    core_clk,
    rst,
    ce,
    s_axi_awaddr,
    s_axi_awvalid,
    s_axi_awready,
    s_axi_wdata,
    s_axi_wstrb,
    s_axi_wvalid,
    s_axi_wready,
    s_axi_bresp,
    s_axi_bvalid,
    s_axi_bready,
    s_axi_araddr,
    s_axi_arvalid,
    s_axi_arready,
    s_axi_rdata,
    s_axi_rresp,
    s_axi_rvalid,
    s_axi_rready,
    fix_type,
    doppler_valid,
    time_valid,
    external_receiver,
    tilt_valid,
    heading_valid,
    float_ambiguity,
    antenna1_disconnected,
    antenna2_disconnected,
    antenna1_shorted,
    antenna2_shorted,
    primary_receiver_failed,
    secondary_receiver_failed,
    pay_data,
    pay_valid,
    pay_ready,
    pay_first,
    pay_last,
    pay_id,
    pay_done,
    pay_bad_id
);
    input  wire              core_clk;
    input  wire              rst;
    input  wire              ce;
    input  wire [ADDR_W-1:0] s_axi_awaddr;
    input  wire              s_axi_awvalid;
    output wire              s_axi_awready;
    input  wire [31:0]       s_axi_wdata;
    input  wire [3:0]        s_axi_wstrb;
    input  wire              s_axi_wvalid;
    output wire              s_axi_wready;
    output reg  [1:0]        s_axi_bresp;
    output reg               s_axi_bvalid;
    input  wire              s_axi_bready;

    input  wire [ADDR_W-1:0] s_axi_araddr;
    input  wire              s_axi_arvalid;
    output wire              s_axi_arready;
    output reg  [31:0]       s_axi_rdata;
    output reg  [1:0]        s_axi_rresp;
    output reg               s_axi_rvalid;
    input  wire              s_axi_rready;

    input  wire [2:0]        fix_type;
    input  wire              doppler_valid;
    input  wire              time_valid;
    input  wire              external_receiver;
    input  wire              tilt_valid;
    input  wire              heading_valid;
    input  wire              float_ambiguity;
    input  wire              antenna1_disconnected;
    input  wire              antenna2_disconnected;
    input  wire              antenna1_shorted;
    input  wire              antenna2_shorted;
    input  wire              primary_receiver_failed;
    input  wire              secondary_receiver_failed;

    output reg  [7:0]        pay_data;
    output reg               pay_valid;
    input  wire              pay_ready;
    output reg               pay_first;
    output reg               pay_last;
    output reg  [7:0]        pay_id;
    output reg               pay_done;
    output reg               pay_bad_id;

    localparam ST_IDLE = 2'b01;
    localparam ST_SEND = 2'b10;

    // Payload words, little-endian, fields packed as software writes them
    reg  [31:0]       mem [0:MEM_WORDS-1];
    reg  [1:0]        state_reg;
    reg  [6:0]        cnt_reg;
    reg  [6:0]        len_reg;
    reg  [5:0]        base_reg;
    reg               bad_id_reg;

    reg               aw_held_reg;
    reg               w_held_reg;
    reg  [ADDR_W-1:0] awaddr_reg;
    reg  [31:0]       wdata_reg;
    reg  [3:0]        wstrb_reg;
    reg  [15:0]       rx_status;
    reg  [31:0]       rd_word;
    reg               rd_ok;
    reg               wr_ok;
    reg  [7:0]        next_byte;
    reg  [7:0]        status_hi_reg;

    wire              do_write;
    wire              dec_known;
    wire [6:0]        dec_len;
    wire [5:0]        dec_base;
    wire [5:0]        word_idx;
    wire [31:0]       cur_word;
    wire              is_ctrl_wr;
    wire              start_req;
    wire              out_free;
    wire              can_load;
    wire              last_taken;
    wire              ant_ok;
    wire              sec_ok;
    wire              busy;
    wire              wr_mem_hit;
    wire              rd_mem_hit;
    wire              stat_clr;
    integer           i;

    assign s_axi_awready = ~aw_held_reg;
    assign s_axi_wready  = ~w_held_reg;
    assign s_axi_arready = ~s_axi_rvalid;
    assign do_write      = aw_held_reg & w_held_reg & ~s_axi_bvalid;
    assign is_ctrl_wr    = do_write & (awaddr_reg == `NPE_OFF_CTRL);
    assign start_req     = is_ctrl_wr & wstrb_reg[1] & wdata_reg[`NPE_CTRL_START_BIT];
    assign stat_clr      = do_write & (awaddr_reg == `NPE_OFF_STAT) & wstrb_reg[0]
                           & wdata_reg[`NPE_STAT_BADID_BIT];
    assign busy          = (state_reg == ST_SEND);
    // Only aligned words inside the payload window reach the memory
    assign wr_mem_hit    = (awaddr_reg >= `NPE_OFF_MEM) & (awaddr_reg <= `NPE_OFF_MEM_END)
                           & (awaddr_reg[1:0] == 2'b00);
    assign rd_mem_hit    = (s_axi_araddr >= `NPE_OFF_MEM) & (s_axi_araddr <= `NPE_OFF_MEM_END)
                           & (s_axi_araddr[1:0] == 2'b00);

    npe_id_decode u_dec (
        .id    (wdata_reg[`NPE_CTRL_ID_LSB +: 8]),
        .known (dec_known),
        .len   (dec_len),
        .base  (dec_base)
    );

    // Inapplicable detection bits read as zero on variants lacking them
    assign ant_ok = (HAS_ANT_DETECT != 0);
    assign sec_ok = (HAS_SECONDARY != 0);

    always @* begin
        rx_status      = 16'h0000;
        rx_status[2:0] = fix_type;
        rx_status[3]   = doppler_valid;
        rx_status[4]   = time_valid;
        rx_status[5]   = external_receiver;
        rx_status[6]   = tilt_valid;
        rx_status[7]   = heading_valid;
        rx_status[8]   = float_ambiguity;
        rx_status[9]   = 1'b0;
        rx_status[10]  = antenna1_disconnected & ant_ok;
        rx_status[11]  = antenna2_disconnected & ant_ok;
        rx_status[12]  = antenna1_shorted & ant_ok;
        rx_status[13]  = antenna2_shorted & ant_ok;
        rx_status[14]  = primary_receiver_failed;
        rx_status[15]  = secondary_receiver_failed & sec_ok;
    end

    // Byte k of a payload lives at byte k of its word region, except raw bytes 72 and 73, which come from the status
    assign word_idx = base_reg + {1'b0, cnt_reg[6:2]};
    assign cur_word = mem[word_idx];

    always @* begin
        case (cnt_reg[1:0])
            2'd0:    next_byte = cur_word[7:0];
            2'd1:    next_byte = cur_word[15:8];
            2'd2:    next_byte = cur_word[23:16];
            default: next_byte = cur_word[31:24];
        endcase
        // Status is live at its low byte; the high byte is frozen then so the word cannot tear
        if (pay_id == `NPE_ID_RAW && cnt_reg == `NPE_RAW_STATUS_LO) begin
            next_byte = rx_status[7:0];
        end else if (pay_id == `NPE_ID_RAW && cnt_reg == `NPE_RAW_STATUS_HI) begin
            next_byte = status_hi_reg;
        end
    end

    assign out_free   = ~pay_valid | pay_ready;
    assign can_load   = busy & (cnt_reg != len_reg) & out_free;
    assign last_taken = pay_valid & pay_ready & pay_last;

    always @* begin
        rd_ok   = 1'b1;
        rd_word = 32'h0000_0000;
        if (s_axi_araddr == `NPE_OFF_STAT) begin
            rd_word[`NPE_STAT_BUSY_BIT]    = busy;
            rd_word[`NPE_STAT_BADID_BIT]   = bad_id_reg;
            rd_word[`NPE_STAT_ID_LSB +: 8] = pay_id;
            rd_word[`NPE_STAT_CNT_LSB +: 7] = cnt_reg;
        end else if (s_axi_araddr == `NPE_OFF_RXSTAT) begin
            rd_word[15:0] = rx_status;
        end else if (s_axi_araddr == `NPE_OFF_CTRL) begin
            rd_word[`NPE_CTRL_ID_LSB +: 8] = pay_id;
        end else if (rd_mem_hit) begin
            rd_word = mem[s_axi_araddr[7:2]];
        end else begin
            rd_ok = 1'b0;
        end
    end

    always @* begin
        wr_ok = (awaddr_reg == `NPE_OFF_CTRL) || (awaddr_reg == `NPE_OFF_STAT) || wr_mem_hit;
    end

    // Payload memory holds data only, so it is left out of reset
    always @(posedge core_clk) begin
        if (ce && do_write && wr_mem_hit) begin
            for (i = 0; i < 4; i = i + 1) begin
                if (wstrb_reg[i]) begin
                    mem[awaddr_reg[7:2]][i*8 +: 8] <= wdata_reg[i*8 +: 8];
                end
            end
        end
    end

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            awaddr_reg   <= {ADDR_W{1'b0}};
            wdata_reg    <= 32'h0000_0000;
            wstrb_reg    <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `NPE_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= `NPE_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_awvalid && !aw_held_reg) begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_held_reg) begin
                w_held_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
                wstrb_reg  <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? `NPE_RESP_OKAY : `NPE_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid && !s_axi_rvalid) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_ok ? `NPE_RESP_OKAY : `NPE_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_reg  <= ST_IDLE;
            cnt_reg    <= 7'h00;
            len_reg    <= 7'h00;
            base_reg   <= 6'h00;
            status_hi_reg <= 8'h00;
            bad_id_reg <= 1'b0;
            pay_data   <= 8'h00;
            pay_valid  <= 1'b0;
            pay_first  <= 1'b0;
            pay_last   <= 1'b0;
            pay_id     <= 8'h00;
            pay_done   <= 1'b0;
            pay_bad_id <= 1'b0;
        end else if (ce) begin
            pay_done   <= 1'b0;
            pay_bad_id <= 1'b0;
            // Clear by writing one; a new bad id in the same cycle wins
            if (stat_clr) begin
                bad_id_reg <= 1'b0;
            end
            case (state_reg)
                ST_IDLE: begin
                    // Start while busy is dropped; software polls busy first
                    if (start_req) begin
                        if (dec_known) begin
                            state_reg <= ST_SEND;
                            cnt_reg   <= 7'h00;
                            len_reg   <= dec_len;
                            base_reg  <= dec_base;
                            pay_id    <= wdata_reg[`NPE_CTRL_ID_LSB +: 8];
                        end else begin
                            bad_id_reg <= 1'b1;
                            pay_bad_id <= 1'b1;
                        end
                    end
                end
                ST_SEND: begin
                    if (can_load) begin
                        pay_data  <= next_byte;
                        pay_valid <= 1'b1;
                        pay_first <= (cnt_reg == 7'h00);
                        pay_last  <= (cnt_reg + 7'h01 == len_reg);
                        cnt_reg   <= cnt_reg + 7'h01;
                        if (pay_id == `NPE_ID_RAW && cnt_reg == `NPE_RAW_STATUS_LO) begin
                            status_hi_reg <= rx_status[15:8];
                        end
                    end else if (pay_valid && pay_ready) begin
                        pay_valid <= 1'b0;
                        pay_first <= 1'b0;
                        pay_last  <= 1'b0;
                    end
                    if (last_taken) begin
                        state_reg <= ST_IDLE;
                        pay_done  <= 1'b1;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // npe_encoder

/* File: npe_encoder_assertions.sv */
`timescale 1ns/1ns
module npe_encoder_assertions (
    input wire       core_clk,
    input wire       rst,
    input wire       s_axi_arready,
    input wire       s_axi_rvalid,
    input wire [7:0] pay_data,
    input wire       pay_valid,
    input wire       pay_ready,
    input wire       pay_first,
    input wire       pay_last,
    input wire [7:0] pay_id,
    input wire       pay_done,
    input wire       pay_bad_id
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    logic [6:0] idx_reg;
    logic [6:0] idx_next;
    logic [6:0] len;
    wire        hs = pay_valid && pay_ready;
    // Zero length marks an id that must never stream
    always_comb begin
        case (pay_id)
            8'h1D: len = 7'h4A;
            8'h1E: len = 7'h0D;
            8'h20, 8'h21: len = 7'h18;
            8'h22: len = 7'h1A;
            8'h23, 8'h24: len = 7'h0C;
            default: len = 7'h00;
        endcase
    end
    assign idx_next = (hs && pay_last) ? 7'h00 : (hs ? idx_reg + 7'h01 : idx_reg);
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            idx_reg <= 7'h00;
        end else begin
            idx_reg <= idx_next;
        end
    end
    chk_pay_stable: assert property (
        pay_valid && !pay_ready |=> pay_valid && $stable(pay_data) && $stable(pay_first) && $stable(pay_last))
        else $error("payload byte changed while stalled");
    chk_first_index: assert property (pay_valid |-> pay_first == (idx_reg == 7'h00))
        else $error("first flag not on byte zero");
    chk_exact_len: assert property (pay_valid |-> pay_last == (idx_reg + 7'h01 == len))
        else $error("last flag not at packet length");
    chk_known_id: assert property (pay_valid |-> len != 7'h00)
        else $error("stream for unknown id");
    chk_done_pulse: assert property (pay_done |=> !pay_done)
        else $error("done longer than one cycle");
    chk_last_done: assert property (hs && pay_last |=> pay_done)
        else $error("no done after last byte");
    chk_done_cause: assert property (pay_done |-> $past(hs && pay_last))
        else $error("done without last byte");
    chk_bad_quiet: assert property (pay_bad_id |-> !pay_valid ##1 !pay_valid)
        else $error("bad id started a stream");
    chk_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
endmodule // npe_encoder_assertions

bind npe_encoder npe_encoder_assertions i_chk (.core_clk(core_clk), .rst(rst), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .pay_data(pay_data), .pay_valid(pay_valid), .pay_ready(pay_ready),
    .pay_first(pay_first), .pay_last(pay_last), .pay_id(pay_id), .pay_done(pay_done), .pay_bad_id(pay_bad_id));

/* File: npe_host_model.sv */
`timescale 1ns/1ns
module npe_host_model (
    input  wire       core_clk,
    input  wire       rst,
    input  wire       stall,
    input  wire       clr,
    input  wire [7:0] pay_data,
    input  wire       pay_valid,
    input  wire       pay_first,
    input  wire       pay_last,
    output logic      pay_ready
);
    logic [7:0] rx_mem [0:127];
    logic [6:0] cnt_reg;
    logic [6:0] last_at_reg;
    logic       flag_err_reg;
    logic [1:0] ph_reg;
    // Slow mode takes one byte in four, so the encoder must hold each byte
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ph_reg <= 2'h0;
            pay_ready <= 1'b0;
            cnt_reg <= 7'h00;
            last_at_reg <= 7'h7F;
            flag_err_reg <= 1'b0;
        end else begin
            ph_reg <= ph_reg + 2'h1;
            pay_ready <= !stall || ph_reg == 2'h2;
            if (clr) begin
                cnt_reg <= 7'h00;
                last_at_reg <= 7'h7F;
                flag_err_reg <= 1'b0;
            end else if (pay_valid && pay_ready) begin
                rx_mem[cnt_reg] <= pay_data;
                cnt_reg <= cnt_reg + 7'h01;
                if (pay_first != (cnt_reg == 7'h00)) begin
                    flag_err_reg <= 1'b1;
                end
                if (pay_last) begin
                    last_at_reg <= cnt_reg;
                end
            end
        end
    end
endmodule // npe_host_model

/* File: nav_packet_payload_encoder_test.sv */
`timescale 1ns/1ns
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin n_errors++; \
    $display("Error %s exp %h got %h", nm, e, s); end end
module nav_packet_payload_encoder_test;
    logic        core_clk = 1'b0;
    logic        rst      = 1'b1;
    logic [11:0] awaddr   = 12'h000;
    logic [11:0] araddr   = 12'h000;
    logic [31:0] wdata    = 32'h0000_0000;
    logic        awvalid  = 1'b0;
    logic        wvalid   = 1'b0;
    logic        bready   = 1'b0;
    logic        arvalid  = 1'b0;
    logic        rready   = 1'b0;
    logic [15:0] st       = 16'h0000;
    logic        stall    = 1'b0;
    logic        clr      = 1'b0;
    wire         awready, wready, bvalid, arready, rvalid;
    wire         pay_valid, pay_ready, pay_first, pay_last, pay_done, pay_bad_id;
    wire  [1:0]  bresp, rresp;
    wire  [31:0] rdata;
    wire  [7:0]  pay_data, pay_id;
    int          n_errors    = 0;
    int          checks_done = 0;
    int          cyc         = 0;
    int          bad_seen    = 0;
    logic [7:0]  ids [7] = '{8'h1D, 8'h1E, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24};
    logic [6:0]  lens [7] = '{7'h4A, 7'h0D, 7'h18, 7'h18, 7'h1A, 7'h0C, 7'h0C};
    int          bases [7] = '{0, 20, 24, 30, 36, 43, 46};

    npe_encoder i_dut (.core_clk(core_clk), .rst(rst), .ce(1'b1),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .fix_type(st[2:0]), .doppler_valid(st[3]), .time_valid(st[4]), .external_receiver(st[5]),
        .tilt_valid(st[6]), .heading_valid(st[7]), .float_ambiguity(st[8]),
        .antenna1_disconnected(st[10]), .antenna2_disconnected(st[11]),
        .antenna1_shorted(st[12]), .antenna2_shorted(st[13]),
        .primary_receiver_failed(st[14]), .secondary_receiver_failed(st[15]),
        .pay_data(pay_data), .pay_valid(pay_valid), .pay_ready(pay_ready), .pay_first(pay_first),
        .pay_last(pay_last), .pay_id(pay_id), .pay_done(pay_done), .pay_bad_id(pay_bad_id));

    npe_host_model i_host (.core_clk(core_clk), .rst(rst), .stall(stall), .clr(clr), .pay_data(pay_data),
        .pay_valid(pay_valid), .pay_first(pay_first), .pay_last(pay_last), .pay_ready(pay_ready));

    always #20 core_clk = ~core_clk;

    task automatic report_and_stop();
        if (n_errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Generous ceiling: the whole sequence needs under a thousand cycles
    always @(posedge core_clk) begin
        cyc++;
        if (pay_bad_id === 1'b1) begin
            bad_seen++;
        end
        if (cyc == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end

    function automatic logic [7:0] pat(input int a);
        pat = (a[7:0] * 8'h3B) ^ 8'h5A;
    endfunction

    task automatic axw(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (1) begin
            @(posedge core_clk);
            if (awvalid && awready) begin
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                wvalid <= 1'b0;
            end
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge core_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (1) begin
            @(posedge core_clk);
            if (arvalid && arready) begin
                arvalid <= 1'b0;
            end
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask

    // Odd packets run against a slow host; the raw packet also gets a start while busy
    task automatic run(input int i);
        logic [1:0]  r;
        logic [31:0] d;
        logic [7:0]  e;
        int          k;
        stall <= i[0];
        clr <= 1'b1;
        @(posedge core_clk);
        clr <= 1'b0;
        axw(12'h000, {23'h0, 1'b1, ids[i]}, r);
        if (i == 0) begin
            axw(12'h000, 32'h0000_0123, r);
        end
        for (k = 0; k < 3000 && pay_done !== 1'b1; k++) begin
            @(posedge core_clk);
        end
        `CHK("byte_count", lens[i], i_host.cnt_reg)
        `CHK("last_index", lens[i] - 7'h01, i_host.last_at_reg)
        `CHK("first_flag", 1'b0, i_host.flag_err_reg)
        for (k = 0; k < lens[i]; k++) begin
            e = (i == 0 && k == 72) ? st[7:0] : ((i == 0 && k == 73) ? st[15:8] & 8'hFD : pat(bases[i] * 4 + k));
            `CHK("payload_byte", e, i_host.rx_mem[k])
        end
        `CHK("pay_id", ids[i], pay_id)
        axr(12'h004, d, r);
        `CHK("stat_id", {ids[i], 8'h00}, {d[15:8], 7'h00, d[0]})
        `CHK("stat_cnt", lens[i], d[22:16])
    endtask

    initial begin
        logic [1:0]  r;
        logic [31:0] d;
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        axr(12'h000, d, r);
        `CHK("ctrl_reset", 32'h0000_0000, d)
        axw(12'h00C, 32'h0000_1234, r);
        `CHK("unmapped_bresp", 2'b10, r)
        axr(12'h00C, d, r);
        `CHK("unmapped_rresp", 2'b10, r)
        st <= 16'hFFFF;
        axr(12'h008, d, r);
        `CHK("status_ones", 32'h0000_FDFF, d)
        st <= 16'hA7C3;
        axr(12'h008, d, r);
        `CHK("status_mix", 32'h0000_A5C3, d)
        for (int w = 0; w < 64; w++) begin
            axw(12'h100 + 12'(4 * w), {pat(4 * w + 3), pat(4 * w + 2), pat(4 * w + 1), pat(4 * w)}, r);
        end
        for (int i = 0; i < 7; i++) begin
            run(i);
        end
        `CHK("no_bad_yet", 0, bad_seen)
        axw(12'h000, 32'h0000_011F, r);
        repeat (3) @(posedge core_clk);
        `CHK("bad_pulse", 1, bad_seen)
        axr(12'h004, d, r);
        `CHK("bad_sticky", 2'b10, d[1:0])
        axw(12'h004, 32'h0000_0002, r);
        axr(12'h004, d, r);
        `CHK("bad_cleared", 1'b0, d[1])
        report_and_stop();
    end
endmodule // nav_packet_payload_encoder_test
